// ### shared/ppr_consts.vh
// constants for the pid process regulator: register map, field widths, reset values, timing
// assumes one 125 MHz clock and an axi4-lite slave with 32-bit data
`ifndef PPR_CONSTS_VH
`define PPR_CONSTS_VH

// register byte offsets
`define PPR_A_CTRL      8'h00
`define PPR_A_GAIN      8'h04
`define PPR_A_ITIME     8'h08
`define PPR_A_DTIME     8'h0C
`define PPR_A_TARGET    8'h10
`define PPR_A_UPPER     8'h14
`define PPR_A_LOWER     8'h18
`define PPR_A_STATUS    8'h1C
`define PPR_A_IRQ_STAT  8'h20
`define PPR_A_IRQ_MASK  8'h24
`define PPR_A_OUTPUT    8'h28

// reset values (settings in their own units)
`define PPR_GAIN_RST    14'h03E8
`define PPR_ITIME_RST   16'h0032
`define PPR_DTIME_RST   10'h000
`define PPR_TARGET_RST  10'h000
`define PPR_UPPER_RST   10'h3E8
`define PPR_LOWER_RST   10'h000

// ranges: gain 0.1 %, integral 0.1 s, differential 0.01 s, levels 0.1 %
`define PPR_GAIN_MAX    14'h2710
`define PPR_ITIME_MIN   16'h0001
`define PPR_ITIME_MAX   16'h8CA0
`define PPR_DTIME_MAX   10'h3E8
`define PPR_PCT_MAX     10'h3E8
`define PPR_PCT_STEP    10'h00A

// feedback ADC: 4 mA -> FB_ZERO, 20 mA -> FB_FULL (12-bit codes)
`define PPR_FB_ZERO     12'h333
`define PPR_FB_FULL     12'hFFF
`define PPR_FB_SPAN     12'hCCC
// target ADC: 0 V -> 0, 10 V -> full 12-bit code
`define PPR_AN_FULL     12'hFFF

// sample period: 10 ms, counted in 8 ns clocks
`define PPR_SAMPLE_NS   32'd10000000
`define PPR_CLK_NS      32'd8
`define PPR_SAMPLES_PER_S 16'd100
// fixed-point units: gain in 0.1 % steps; integrator kept 1000x finer so long times still move
`define PPR_GAIN_UNIT   36'sh3E8
`define PPR_INT_UNIT    32'sh3E8

// status and irq bits
`define PPR_ST_UPPER    0
`define PPR_ST_LOWER    1
`define PPR_ST_ACTIVE   2
`define PPR_ST_SAT      3
`define PPR_IRQ_W       4
`define PPR_CTRL_SRC    0

`define PPR_RESP_OKAY   2'b00
`define PPR_RESP_SLVERR 2'b10

`endif

// ### rtl/ppr_scale.v
// converts raw adc codes of feedback and analog target into 0.1 % units
// assumes 12-bit unsigned codes already synchronised to aclk
`include "ppr_consts.vh"

module ppr_scale
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] fb_code,
  input  wire [11:0] an_code,
  output reg  [9:0]  fb_pct_q,
  output reg  [9:0]  an_pct_q
);

  wire [11:0] fb_off;
  wire [21:0] fb_prod;
  wire [21:0] an_prod;
  wire [21:0] fb_quo;
  wire [21:0] an_quo;

  // current below 4 mA (broken loop) reads as 0 %
  assign fb_off  = (fb_code > `PPR_FB_ZERO) ? (fb_code - `PPR_FB_ZERO) : 12'h000;
  assign fb_prod = fb_off * `PPR_PCT_MAX;
  assign an_prod = an_code * `PPR_PCT_MAX;
  assign fb_quo  = fb_prod / {10'h000, `PPR_FB_SPAN};
  assign an_quo  = an_prod / {10'h000, `PPR_AN_FULL};

  // registered, feedback clamped to 100.0 %
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fb_pct_q <= 10'h000;
      an_pct_q <= 10'h000;
    end
    else
    begin
      fb_pct_q <= (fb_quo > {12'h000, `PPR_PCT_MAX}) ? `PPR_PCT_MAX : fb_quo[9:0];
      an_pct_q <= an_quo[9:0];
    end
  end

endmodule // ppr_scale

// ### rtl/ppr_sync.v
// two-flop synchroniser for a bus of pin-level inputs
// assumes the inputs change slowly or are quasi-static words
module ppr_sync
#(
  parameter W = 1
)
(
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_q
);

  reg [W-1:0] meta_q;

  // first stage read only by the second
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

endmodule // ppr_sync

// ### rtl/ppr_top.v
// pid process regulator with axi4-lite settings, limit flags and interrupt
// assumes one clock aclk (125 MHz), sync active-low reset, adc codes and enable from pins
// Function
// R1 - error times gain, 0.1% steps, default 100%
// R2 - zero integral and differential: proportional only; itime clamps to at least 0.1 s, so the integral term always runs
// R3 - integral time 0.1..3600 s, default 5 s
// R4 - longer integral time accumulates more slowly
// R5 - differential time 0.01..10 s, default zero
// R6 - zero differential time omits differential term
// R7 - target 0..100% in 1% steps, 10V full
// R8 - source select: stored target or analog input
// R9 - flag while feedback above upper limit
// R10 - flag while feedback below lower limit
// R11 - transmitter supplies 4-20mA feedback current
// R12 - regulate only while enable input asserted
// R13 - fixed sample period, saturate output and integrator
`include "ppr_consts.vh"

module ppr_top
#(
  parameter [31:0] SAMPLE_CYC = `PPR_SAMPLE_NS / `PPR_CLK_NS
)
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [11:0] fb_adc_code,
  input  wire [11:0] target_adc_code,
  input  wire        pid_enable_in,
  output reg  [9:0]  pid_out_q,
  output reg         pid_out_valid_q,
  output reg         upper_flag_q,
  output reg         lower_flag_q,
  output reg         irq_q
);

  localparam [31:0] ACC_MAX    = 32'h3FFFFFFF;

  // settings registers
  reg        src_sel_q;
  reg [13:0] gain_q;
  reg [15:0] itime_q;
  reg [9:0]  dtime_q;
  reg [9:0]  target_q;
  reg [9:0]  upper_q;
  reg [9:0]  lower_q;
  reg [`PPR_IRQ_W-1:0] irq_stat_q;
  reg [`PPR_IRQ_W-1:0] irq_mask_q;

  // bus state
  reg        aw_held_q;
  reg        w_held_q;
  reg [7:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;

  // loop state
  reg [31:0] tick_cnt_q;
  reg        tick_q;
  reg signed [31:0] integ_q;
  reg signed [11:0] prev_err_q;
  reg        sat_q;

  wire [24:0] sync_bus;
  wire [11:0] fb_code_s;
  wire [11:0] an_code_s;
  wire        en_s;
  wire [9:0]  fb_pct;
  wire [9:0]  an_pct;

  // pins cross into aclk before any logic sees them
  ppr_sync #(.W(25)) u_sync
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({pid_enable_in, target_adc_code, fb_adc_code}),
    .sync_q   (sync_bus)
  );

  assign fb_code_s = sync_bus[11:0];
  assign an_code_s = sync_bus[23:12];
  assign en_s      = sync_bus[24];

  // feedback path is the 4-20 mA loop current
  ppr_scale u_scale
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .fb_code  (fb_code_s), // R11
    .an_code  (an_code_s),
    .fb_pct_q (fb_pct),
    .an_pct_q (an_pct)
  );

  // clamp a setting into its legal range
  function [15:0] clamp16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // round a percentage down to whole 1 % steps
  function [9:0] whole_pct;
    input [9:0] v;
    begin
      whole_pct = v - (v % `PPR_PCT_STEP);
    end
  endfunction

  // target selection
  wire [9:0] target_sel = src_sel_q ? whole_pct(an_pct) : target_q; // R7 R8
  wire signed [11:0] err = $signed({2'b00, target_sel}) - $signed({2'b00, fb_pct});

  // proportional, integral and differential arithmetic
  wire signed [27:0] p_term  = err * $signed({1'b0, gain_q}); // R1
  wire signed [31:0] integ_s = integ_q + ((p_term * $signed(`PPR_SAMPLES_PER_S)) /
                                          $signed({1'b0, itime_q})); // R3 R4
  wire signed [31:0] integ_c = (integ_s > $signed(ACC_MAX)) ? $signed(ACC_MAX) :
                               ((integ_s < -$signed(ACC_MAX)) ? -$signed(ACC_MAX) : integ_s);
  wire signed [12:0] derr    = err - prev_err_q;
  // full product width: error step times gain times dtime overflows 32 bits
  wire signed [35:0] d_term  = (dtime_q == 10'h000) ? 36'sh0 : // R6
                               derr * $signed({1'b0, gain_q}) * $signed({1'b0, dtime_q});
  // integral time has no off setting, so i always accumulates; dtime zero drops d, leaving p plus i
  wire signed [35:0] sum_raw = (p_term + integ_c / `PPR_INT_UNIT + d_term) / `PPR_GAIN_UNIT; // R2
  wire        sum_hi  = sum_raw > $signed({26'h0, `PPR_PCT_MAX});
  wire        sum_lo  = sum_raw < 36'sh0;
  wire [9:0]  sum_sat = sum_hi ? `PPR_PCT_MAX : (sum_lo ? 10'h000 : sum_raw[9:0]);

  // sample tick from the system clock; limit flags only, the drive keeps running
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tick_cnt_q   <= 32'h0;
      tick_q       <= 1'b0;
      upper_flag_q <= 1'b0;
      lower_flag_q <= 1'b0;
    end
    else
    begin
      tick_q       <= (tick_cnt_q == SAMPLE_CYC - 32'h1); // R13
      tick_cnt_q   <= (tick_cnt_q == SAMPLE_CYC - 32'h1) ? 32'h0 : tick_cnt_q + 32'h1;
      upper_flag_q <= fb_pct > upper_q; // R9
      lower_flag_q <= fb_pct < lower_q; // R10
    end
  end

  // loop update once per tick; held at zero while disabled
  always @(posedge aclk)
  begin
    if (!aresetn || !en_s)
    begin
      integ_q         <= 32'sh0; // R12
      prev_err_q      <= 12'sh0;
      pid_out_q       <= 10'h000;
      pid_out_valid_q <= 1'b0;
      sat_q           <= 1'b0;
    end
    else if (tick_q)
    begin
      integ_q         <= integ_c; // R13
      prev_err_q      <= err;
      pid_out_q       <= sum_sat; // R13
      pid_out_valid_q <= 1'b1;
      sat_q           <= sum_hi | sum_lo;
    end
  end

  // rising edges of the flags and saturation, and each tick while enabled, are interrupt events
  reg up_d1_q;
  reg lo_d1_q;
  reg sat_d1_q;
  wire [`PPR_IRQ_W-1:0] irq_ev = {sat_q & ~sat_d1_q, en_s & tick_q,
                                  lower_flag_q & ~lo_d1_q, upper_flag_q & ~up_d1_q};

  // axi write channel: accept address and data in either order
  wire wr_go = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire [31:0] wd = wdata_q;
  wire [`PPR_IRQ_W-1:0] w1c = (wr_go && awaddr_q == `PPR_A_IRQ_STAT && wstrb_q[0]) ?
                              wd[`PPR_IRQ_W-1:0] : {`PPR_IRQ_W{1'b0}};
  // clamped setting values, cut to each register's width where used
  wire [15:0] gain_lim  = clamp16({2'b00, wd[13:0]}, 16'h0, {2'b00, `PPR_GAIN_MAX});
  wire [15:0] dtime_lim = clamp16({6'h0, wd[9:0]}, 16'h0, {6'h0, `PPR_DTIME_MAX});
  wire [15:0] pct_lim   = clamp16({6'h0, wd[9:0]}, 16'h0, {6'h0, `PPR_PCT_MAX});

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PPR_RESP_OKAY;
      src_sel_q     <= 1'b0;
      gain_q        <= `PPR_GAIN_RST;
      itime_q       <= `PPR_ITIME_RST;
      dtime_q       <= `PPR_DTIME_RST;
      target_q      <= `PPR_TARGET_RST;
      upper_q       <= `PPR_UPPER_RST;
      lower_q       <= `PPR_LOWER_RST;
      irq_mask_q    <= {`PPR_IRQ_W{1'b0}};
    end
    else
    begin
      s_axi_awready <= ~aw_held_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready  <= ~w_held_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awready && s_axi_awvalid)
      begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wready && s_axi_wvalid)
      begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (wr_go)
      begin
        aw_held_q    <= 1'b0;
        w_held_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `PPR_RESP_OKAY;
        // settings take effect whole-word, clamped to their legal ranges
        case (awaddr_q)
          `PPR_A_CTRL:     src_sel_q  <= wd[`PPR_CTRL_SRC]; // R8
          `PPR_A_GAIN:     gain_q     <= gain_lim[13:0]; // R1
          `PPR_A_ITIME:    itime_q    <= clamp16(wd[15:0], `PPR_ITIME_MIN,
                                                 `PPR_ITIME_MAX); // R3
          `PPR_A_DTIME:    dtime_q    <= dtime_lim[9:0]; // R5
          `PPR_A_TARGET:   target_q   <= whole_pct(pct_lim[9:0]); // R7
          `PPR_A_UPPER:    upper_q    <= pct_lim[9:0];
          `PPR_A_LOWER:    lower_q    <= pct_lim[9:0];
          `PPR_A_IRQ_MASK: irq_mask_q <= wd[`PPR_IRQ_W-1:0];
          `PPR_A_STATUS, `PPR_A_IRQ_STAT, `PPR_A_OUTPUT: s_axi_bresp <= `PPR_RESP_OKAY;
          default:         s_axi_bresp <= `PPR_RESP_SLVERR;
        endcase
      end
    end
  end

  // sticky status: a new event beats a same-cycle clear
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat_q <= {`PPR_IRQ_W{1'b0}};
      up_d1_q    <= 1'b0;
      lo_d1_q    <= 1'b0;
      sat_d1_q   <= 1'b0;
      irq_q      <= 1'b0;
    end
    else
    begin
      irq_stat_q <= (irq_stat_q & ~w1c) | irq_ev;
      up_d1_q    <= upper_flag_q;
      lo_d1_q    <= lower_flag_q;
      sat_d1_q   <= sat_q;
      irq_q      <= |(((irq_stat_q & ~w1c) | irq_ev) & irq_mask_q);
    end
  end

  // read data mux
  reg [31:0] rd_mux;
  reg        rd_ok;
  always @*
  begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0;
    case (s_axi_araddr)
      `PPR_A_CTRL:     rd_mux = {31'h0, src_sel_q};
      `PPR_A_GAIN:     rd_mux = {18'h0, gain_q};
      `PPR_A_ITIME:    rd_mux = {16'h0, itime_q};
      `PPR_A_DTIME:    rd_mux = {22'h0, dtime_q};
      `PPR_A_TARGET:   rd_mux = {22'h0, target_q};
      `PPR_A_UPPER:    rd_mux = {22'h0, upper_q};
      `PPR_A_LOWER:    rd_mux = {22'h0, lower_q};
      `PPR_A_STATUS:   rd_mux = {6'h0, fb_pct, 12'h0, sat_q, en_s, lower_flag_q, upper_flag_q};
      `PPR_A_IRQ_STAT: rd_mux = {28'h0, irq_stat_q};
      `PPR_A_IRQ_MASK: rd_mux = {28'h0, irq_mask_q};
      `PPR_A_OUTPUT:   rd_mux = {6'h0, target_sel, 6'h0, pid_out_q};
      default:         rd_ok  = 1'b0;
    endcase
  end

  // read channel: one-cycle arready, data the cycle after
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `PPR_RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (s_axi_arready && s_axi_arvalid)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `PPR_RESP_OKAY : `PPR_RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // ppr_top

// ### tb/ppr_chk_assertions.sv
// concurrent checks on the regulator top: bus answers, disable behaviour, output range
// assumes it is bound into ppr_top and sees only that module's ports
module ppr_chk
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        pid_enable_in,
  input logic [9:0]  pid_out_q,
  input logic        pid_out_valid_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // both halves of a write taken together, and a read request taken
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // pin held low long enough to pass the two-flop synchroniser
  sequence s_off_long;
    !pid_enable_in [*5];
  endsequence

  chk_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write request got no response in time");
  chk_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data did not follow the request");
  chk_bresp_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated without a request");
  chk_rresp_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read response repeated without a request");
  chk_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready held for two cycles");
  chk_off_out_zero: assert property (s_off_long |-> pid_out_q == 10'h000)
    else $error("output applied while regulation is off");
  chk_off_no_valid: assert property (s_off_long |-> !pid_out_valid_q)
    else $error("output valid while regulation is off");
  chk_out_in_range: assert property (pid_out_q <= 10'h3E8)
    else $error("output beyond full scale");
endmodule // ppr_chk

bind ppr_top ppr_chk i_ppr_chk (.*);

// ### tb/ppr_proc_src.sv
// far-side model: 4-20 mA process transmitter and 0-10 V target source as adc codes
// assumes levels in 0.1 % units; codes rounded up so floor scaling gives the level back
`include "ppr_consts.vh"
module ppr_proc_src
(
  input  logic        aclk,
  input  logic [9:0]  fb_pct,
  input  logic [9:0]  an_pct,
  output logic [11:0] fb_adc_code = 12'h333,
  output logic [11:0] target_adc_code = 12'h000
);
  timeunit 1ns;
  timeprecision 1ps;
  // transmitter never drops under its 4 mA floor; one clock of settling
  always @(posedge aclk)
  begin
    fb_adc_code     <= 12'(`PPR_FB_ZERO + (int'(fb_pct) * `PPR_FB_SPAN + 999) / 1000);
    target_adc_code <= 12'((int'(an_pct) * `PPR_AN_FULL + 999) / 1000);
  end
endmodule // ppr_proc_src

// ### tb/tb_ppr_top.sv
// self-checking bench for ppr_top: settings, limit flags, interrupt, target source, enable
// assumes ppr_consts.vh on the include path; sample period cut to 200 clocks to fit the run
`include "ppr_consts.vh"
module tb_ppr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready = 1'b0;
  logic [11:0] fb_adc_code;
  logic [11:0] target_adc_code;
  logic        pid_enable_in = 1'b0;
  logic [9:0]  pid_out_q;
  logic        pid_out_valid_q;
  logic        upper_flag_q;
  logic        lower_flag_q;
  logic        irq_q;
  logic [9:0]  fb_pct = 10'h000;
  logic [9:0]  an_pct = 10'h000;
  logic [31:0] rd;
  logic [1:0]  rs;
  int          bad_count = 0;
  int          total_checks = 0;
  int          cyc_q = 0;
  int          v;
  int          p;
  int          mdl[11];
  int          rst_v[11] = '{0, 1000, 50, 0, 0, 1000, 0, 0, 0, 0, 0};
  int          fmax[7] = '{1, 16383, 65535, 1023, 1023, 1023, 1023};
  int          g, it, dt, e, ep, ig, ex;

  // short sample period: the real 10 ms tick would not fall inside the run
  ppr_top #(.SAMPLE_CYC(200)) i_ppr_top (.*);
  ppr_proc_src i_ppr_proc_src (.*);

  always #4 aclk = ~aclk;

  // register model: clamping and whole-percent target
  function automatic int clampv(input int a, input int x);
    case (a)
      0: return x & 1;
      1: return x > 10000 ? 10000 : x;
      2: return x < 1 ? 1 : (x > 36000 ? 36000 : x);
      4: return (x > 1000 ? 1000 : x) / 10 * 10;
      default: return x > 1000 ? 1000 : x;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic test_done;
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // outputs sampled at the falling edge, well clear of updates
  task automatic wait_n(input int n);
    repeat (n) @(posedge aclk);
    @(negedge aclk);
  endtask

  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_p || w_p)
    begin
      @(negedge aclk);
      aw_p = aw_p && (s_axi_awready !== 1'b1);
      w_p = w_p && (s_axi_wready !== 1'b1);
      @(posedge aclk);
      s_axi_awvalid <= aw_p;
      s_axi_wvalid <= w_p;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  // hang guard: far above the roughly 1200 cycles the sequence needs
  always @(posedge aclk)
  begin
    cyc_q <= cyc_q + 1;
    if (cyc_q == 20000)
    begin
      bad_count++;
      test_done();
    end
  end

  initial
  begin
    void'($urandom(32'hB0E9));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values of the whole map
    foreach (rst_v[a])
    begin
      axi_rd(8'(a * 4), rd, rs);
      chk("reset value", rst_v[a], rd);
    end
    // zero, field maximum and a random value into each of the seven settings, ctrl to lower
    foreach (fmax[a])
      for (int k = 0; k < 3; k++)
      begin
        v = (k == 0) ? 0 : (k == 1) ? fmax[a] : $urandom_range(fmax[a]);
        axi_wr(8'(a * 4), v, rs);
        mdl[a] = clampv(a, v);
        axi_rd(8'(a * 4), rd, rs);
        chk("setting readback", mdl[a], rd);
      end
    axi_wr(8'h80, 32'h00000001, rs);
    chk("unmapped write", `PPR_RESP_SLVERR, rs);
    axi_rd(8'h80, rd, rs);
    chk("unmapped read", `PPR_RESP_SLVERR, rs);
    chk("unmapped data", 32'h00000000, rd);
    axi_wr(`PPR_A_STATUS, 32'hFFFFFFFF, rs);
    chk("status write", `PPR_RESP_OKAY, rs);
    // limit flags against random feedback levels
    axi_wr(`PPR_A_UPPER, 600, rs);
    axi_wr(`PPR_A_LOWER, 300, rs);
    for (int k = 0; k < 8; k++)
    begin
      p = (k == 0) ? 605 : (k == 1) ? 295 : $urandom_range(1000);
      @(posedge aclk) fb_pct <= 10'(p);
      wait_n(10);
      chk("upper flag", p > 600, upper_flag_q);
      chk("lower flag", p < 300, lower_flag_q);
      axi_rd(`PPR_A_STATUS, rd, rs);
      chk("status", (p << 16) | ((p < 300) << 1) | (p > 600), rd & 32'h03FF000F);
    end
    // interrupt on upper flag rise: masked, unmasked, cleared
    @(posedge aclk) fb_pct <= 10'h000;
    wait_n(10);
    axi_wr(`PPR_A_IRQ_STAT, 32'h0000000F, rs);
    @(posedge aclk) fb_pct <= 10'h384;
    wait_n(10);
    chk("irq masked", 1'b0, irq_q);
    axi_rd(`PPR_A_IRQ_STAT, rd, rs);
    chk("irq status", 32'h00000001, rd);
    axi_wr(`PPR_A_IRQ_MASK, 32'h00000001, rs);
    wait_n(2);
    chk("irq raised", 1'b1, irq_q);
    axi_wr(`PPR_A_IRQ_STAT, 32'h00000001, rs);
    wait_n(2);
    chk("irq cleared", 1'b0, irq_q);
    // stored target, then analog target floored to whole percent
    axi_wr(`PPR_A_TARGET, 555, rs);
    axi_wr(`PPR_A_CTRL, 0, rs);
    axi_rd(`PPR_A_OUTPUT, rd, rs);
    chk("stored target", 550 << 16, rd);
    p = $urandom_range(1000);
    @(posedge aclk) an_pct <= 10'(p);
    axi_wr(`PPR_A_CTRL, 1, rs);
    wait_n(10);
    axi_rd(`PPR_A_OUTPUT, rd, rs);
    chk("analog target", (p / 10 * 10) << 16, rd);
    // closed loop: random settings, then three ticks against the integer model
    g = 1 + $urandom_range(1999);
    it = 1 + $urandom_range(999);
    dt = $urandom_range(2);
    p = $urandom_range(100) * 10;
    v = $urandom_range(1000);
    axi_wr(`PPR_A_CTRL, 0, rs);
    axi_wr(`PPR_A_GAIN, g, rs);
    axi_wr(`PPR_A_ITIME, it, rs);
    axi_wr(`PPR_A_DTIME, dt, rs);
    axi_wr(`PPR_A_TARGET, p, rs);
    @(posedge aclk) fb_pct <= 10'(v);
    wait_n(250);
    chk("no early sample", 1'b0, pid_out_valid_q);
    @(posedge aclk) pid_enable_in <= 1'b1;
    for (int n = 0; n < 300 && pid_out_valid_q !== 1'b1; n++)
      wait_n(0);
    chk("first sample", 1'b1, pid_out_valid_q);
    e = p - v;
    ep = 0;
    ig = 0;
    for (int t = 0; t < 3; t++)
    begin
      ig = ig + e * g * 100 / it;
      ig = ig > 1073741823 ? 1073741823 : (ig < -1073741823 ? -1073741823 : ig);
      ex = (e * g + ig / 1000 + (dt == 0 ? 0 : (e - ep) * g * dt)) / 1000;
      ex = ex > 1000 ? 1000 : (ex < 0 ? 0 : ex);
      ep = e;
      if (t > 0)
        wait_n(200);
      chk("regulator output", ex, pid_out_q);
    end
    axi_rd(`PPR_A_IRQ_STAT, rd, rs);
    chk("tick event", 1'b1, rd[2]);
    axi_rd(`PPR_A_STATUS, rd, rs);
    chk("enable status", 1'b1, rd[2]);
    @(posedge aclk) pid_enable_in <= 1'b0;
    wait_n(8);
    chk("output off", 10'h000, pid_out_q);
    chk("valid off", 1'b0, pid_out_valid_q);
    test_done();
  end
endmodule // tb_ppr_top
